// ### vcc_cal_ctrl.sv
// Overview of operation
// - Three monitors flag slow reference or oscillator
// - Oscillator monitor watches external clock when selected
// - Threshold bit selects normal or extended limit for the references
// - Calibration clocked from divided phase compare rate pulse
// - Autoload triggers an automatic calibration
// - Later calibrations need start 0 then 1
// - Done status bit reads 1 after calibration
// - Sync, calibrate, release, close loop, done
// - Sync released without waiting for settling
// - Calibration clock is compare rate over divider
// - Calibration lasts 4400 calibration clocks
// - No automatic recalibration on setting changes
module vcc_cal_ctrl #(
    parameter int CAL_CYCLES = vcc_pkg::VCC_CAL_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Register port
    input wire logic [vcc_pkg::VCC_ADDR_W-1:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rd_data_out,
    // Loop and loader events
    input wire logic phase_compare_rate_pulse_in,
    input wire logic autoload_cal_in,
    // Monitored clock pins
    input wire logic reference_input_1_in,
    input wire logic reference_input_2_in,
    input wire logic osc_clk_in,
    input wire logic ext_clk_in,
    // Distribution, loop control and monitor flags
    output logic output_sync_out,
    output logic loop_close_out,
    output logic [2:0] osc_div_out,
    output logic [2:0] mon_slow_out,
    // Interrupt
    output logic irq_out
);
    import vcc_pkg::*;

    typedef struct packed {
        logic start_buf;
        logic [1:0] div_buf;
        logic thr_buf;
        logic [2:0] osc_buf;
        logic start_act;
        logic [1:0] div_act;
        logic thr_act;
        logic [2:0] osc_act;
        logic ext_sel;
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        vcc_state_t state;
        logic [3:0] div_cnt;
        logic [12:0] cal_cnt;
        logic done;
        logic sync;
        logic loop_close;
        logic [2:0] mon_flag;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic irq;
        logic [7:0] rdata;
    } vcc_regs_t;

    vcc_regs_t r;
    vcc_regs_t next_r;
    logic [2:0] mon_src;
    logic [2:0] mon_slow;
    logic [15:0] ref_limit;
    logic update;
    logic cal_req;
    logic [3:0] div_last;
    logic cal_tick;
    logic [3:0] events;

    // Threshold and clock selection for the monitors
    // The select acts on synchronised pins, so no raw clock meets the mux
    assign ref_limit = r.thr_act ? VCC_MON_EXT_LIMIT : VCC_MON_NORMAL_LIMIT;
    assign mon_src[0] = r.pin_s2[0];
    assign mon_src[1] = r.pin_s2[1];
    assign mon_src[2] = r.ext_sel ? r.pin_s2[3] : r.pin_s2[2];

    // The oscillator monitor keeps the normal limit; only references use the extended one

    // One slow-clock monitor per watched input
    generate
        for (genvar g = 0; g < 3; g++) begin : g_mon
            vcc_freq_monitor #(
                .CNT_W(VCC_CNT_W)
            ) u_mon (
                .clk_sys_in(clk_sys_in),
                .rst_in(rst_in),
                .watch_pin_in(mon_src[g]),
                .limit_in((g < 2) ? ref_limit : VCC_MON_NORMAL_LIMIT),
                .slow_out(mon_slow[g])
            );
        end
    endgenerate

    // Update strobe and calibration requests
    assign update = wr_in && (addr_in == VCC_ADR_UPDATE) && wr_data_in[VCC_UPDATE_BIT];
    // Besides autoload, only a 0 to 1 transfer of the start bit asks for a calibration, so an
    // update that leaves the start bit at 1 restarts nothing
    assign cal_req = (update && r.start_buf && !r.start_act) || autoload_cal_in;
    assign div_last = 4'((2 << r.div_act) - 1);
    assign cal_tick = phase_compare_rate_pulse_in && (r.div_cnt == div_last);
    // Monitor events fire once, in the cycle a flag first rises
    assign events = {mon_slow & ~r.mon_flag, r.state == VCC_CLOSE};

    // Next-state logic
    always_comb begin
        next_r = r;
        next_r.rdata = 8'h00;
        next_r.mon_flag = mon_slow;
        // Two flip-flops on every clock pin before any selection
        next_r.pin_s1 = {ext_clk_in, osc_clk_in, reference_input_2_in, reference_input_1_in};
        next_r.pin_s2 = r.pin_s1;
        // Calibration, threshold and divider writes go to the buffered copies; mask and external select are written directly
        if (wr_in) begin
            case (addr_in)
                VCC_ADR_CAL_CTRL: begin
                    next_r.start_buf = wr_data_in[VCC_CAL_START_BIT];
                    next_r.div_buf = wr_data_in[VCC_CAL_DIV_LSB +: 2];
                end
                VCC_ADR_MON_CTRL: begin
                    next_r.thr_buf = wr_data_in[VCC_MON_THR_BIT];
                end
                VCC_ADR_OSC_DIV: begin
                    next_r.osc_buf = wr_data_in[2:0];
                end
                VCC_ADR_IRQ_MASK: begin
                    next_r.irq_mask = wr_data_in[3:0];
                end
                VCC_ADR_AUX_CTRL: begin
                    next_r.ext_sel = wr_data_in[VCC_EXT_SEL_BIT];
                end
                default: begin
                end
            endcase
        end
        // Update strobe moves buffered settings into the active copies
        // Settings moved while busy act at once; software keeps them steady then
        if (update) begin
            next_r.start_act = r.start_buf;
            next_r.div_act = r.div_buf;
            next_r.thr_act = r.thr_buf;
            next_r.osc_act = r.osc_buf;
        end
        // Calibration sequence
        case (r.state)
            VCC_IDLE: begin
                if (cal_req) begin
                    next_r.done = 1'b0;
                    next_r.sync = 1'b1;
                    next_r.loop_close = 1'b0;
                    next_r.div_cnt = 4'h0;
                    next_r.cal_cnt = 13'h0000;
                    next_r.state = VCC_SYNC;
                end
            end
            VCC_SYNC: begin
                next_r.state = VCC_CAL;
            end
            VCC_CAL: begin
                // The phase pulse is divided down to the calibration tick here
                if (phase_compare_rate_pulse_in) begin
                    next_r.div_cnt = cal_tick ? 4'h0 : r.div_cnt + 4'h1;
                end
                if (cal_tick) begin
                    if (r.cal_cnt == 13'(CAL_CYCLES - 1)) begin
                        next_r.state = VCC_RELEASE;
                    end else begin
                        next_r.cal_cnt = r.cal_cnt + 13'h0001;
                    end
                end
            end
            VCC_RELEASE: begin
                // Sync drops without waiting for the loop to settle
                next_r.sync = 1'b0;
                next_r.state = VCC_CLOSE;
            end
            VCC_CLOSE: begin
                next_r.loop_close = 1'b1;
                next_r.done = 1'b1;
                next_r.state = VCC_IDLE;
            end
            default: begin
                next_r.state = VCC_IDLE;
            end
        endcase
        // Sticky interrupt status: write one clears, new event wins
        // A clear in the same cycle as an event loses, so no event is missed
        if (wr_in && addr_in == VCC_ADR_IRQ_STAT) begin
            next_r.irq_stat = r.irq_stat & ~wr_data_in[3:0];
        end
        next_r.irq_stat = next_r.irq_stat | events;
        next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
        // Read data one cycle after the strobe
        if (rd_in) begin
            case (addr_in)
                VCC_ADR_CAL_CTRL: next_r.rdata = {5'h00, r.div_buf, r.start_buf};
                VCC_ADR_MON_CTRL: next_r.rdata = {1'b0, r.thr_buf, 6'h00};
                VCC_ADR_STATUS: next_r.rdata = {1'b0, r.done, r.state != VCC_IDLE, 2'h0, r.mon_flag};
                VCC_ADR_OSC_DIV: next_r.rdata = {5'h00, r.osc_buf};
                VCC_ADR_IRQ_STAT: next_r.rdata = {4'h0, r.irq_stat};
                VCC_ADR_IRQ_MASK: next_r.rdata = {4'h0, r.irq_mask};
                VCC_ADR_AUX_CTRL: next_r.rdata = {7'h00, r.ext_sel};
                default: next_r.rdata = 8'h00;
            endcase
        end
    end

    // State register
    // Reset values come from the package; everything else clears
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
            r.div_buf <= VCC_CAL_DIV_RST;
            r.div_act <= VCC_CAL_DIV_RST;
            r.osc_buf <= VCC_OSC_DIV_RST;
            r.osc_act <= VCC_OSC_DIV_RST;
            r.irq_mask <= VCC_IRQ_MASK_RST;
            r.state <= VCC_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flip-flops
    assign rd_data_out = r.rdata;
    assign output_sync_out = r.sync;
    assign loop_close_out = r.loop_close;
    assign osc_div_out = r.osc_act;
    assign mon_slow_out = r.mon_flag;
    assign irq_out = r.irq;

    // Assertions run on the system clock and rest during reset
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    AST_DONE_CLEARS: assert property (r.state == VCC_IDLE && cal_req |=> !r.done && r.sync)
        else $error("done not cleared at calibration start");
    AST_SYNC_HELD: assert property (r.state == VCC_CAL |-> r.sync && !r.loop_close)
        else $error("outputs not held static during calibration");
    AST_RELEASE_ORDER: assert property ($fell(r.sync) |-> !r.loop_close ##1 r.loop_close && r.done)
        else $error("loop closed out of order");
    AST_SYNC_ENTRY: assert property ($rose(r.sync) |-> r.state == VCC_SYNC)
        else $error("sync raised outside calibration start");
    AST_SYNC_EXIT: assert property (r.state == VCC_SYNC |=> r.state == VCC_CAL && r.sync)
        else $error("calibration did not follow sync");
    AST_CAL_HOLD: assert property (r.state == VCC_CAL && !cal_tick |=> r.state == VCC_CAL)
        else $error("calibration left without a tick");
    AST_RELEASE_NEXT: assert property (r.state == VCC_RELEASE |=> r.state == VCC_CLOSE && !r.sync)
        else $error("sync not released before loop close");
    AST_LOOP_OPEN: assert property (r.state != VCC_IDLE |-> !r.loop_close)
        else $error("loop closed during calibration");
    AST_IDLE_NO_SYNC: assert property (r.state == VCC_IDLE |-> !r.sync)
        else $error("sync held while idle");
    AST_DONE_LOW_BUSY: assert property (r.state != VCC_IDLE |-> !r.done)
        else $error("done set while calibrating");
    AST_DONE_SET: assert property (r.state == VCC_CLOSE |=> r.done && r.loop_close && r.state == VCC_IDLE)
        else $error("done not set at calibration end");
    AST_DONE_KEPT: assert property (r.state == VCC_IDLE && r.done && !cal_req |=> r.done)
        else $error("done lost while idle");
    AST_NO_SELF_START: assert property (r.state == VCC_IDLE && !cal_req |=> r.state == VCC_IDLE)
        else $error("calibration started without request");
    AST_START_EDGE: assert property (r.state == VCC_IDLE && update && r.start_act && !autoload_cal_in
        |=> r.state == VCC_IDLE)
        else $error("calibration started without 0 to 1 transfer");
    AST_AUTOLOAD: assert property (r.state == VCC_IDLE && autoload_cal_in |=> r.state == VCC_SYNC ##1 r.state == VCC_CAL)
        else $error("autoload did not start calibration");
    AST_CAL_LENGTH: assert property (r.state == VCC_CAL && cal_tick && r.cal_cnt == 13'(CAL_CYCLES - 1)
        |=> r.state == VCC_RELEASE)
        else $error("calibration length wrong");
    AST_CAL_STEP: assert property (r.state == VCC_CAL && phase_compare_rate_pulse_in && r.div_cnt != div_last
        |=> $stable(r.cal_cnt))
        else $error("calibration clock not divided");
    // Register, monitor and interrupt checks
    AST_THRESHOLD: assert property (update |=> r.thr_act == $past(r.thr_buf))
        else $error("reference threshold select wrong");
    AST_THR_HOLD: assert property (!update |=> $stable(r.thr_act))
        else $error("threshold changed without update");
    AST_DIV_HOLD: assert property (!update |=> $stable(r.div_act))
        else $error("calibration divider changed without update");
    AST_OSC_LOAD: assert property (update |=> r.osc_act == $past(r.osc_buf))
        else $error("oscillator divider not taken at update");
    AST_IRQ_SET_WINS: assert property (r.state == VCC_CLOSE |=> r.irq_stat[0])
        else $error("calibration event not recorded");
    AST_IRQ_LEVEL: assert property (r.irq == |(r.irq_stat & r.irq_mask))
        else $error("interrupt level wrong");
    AST_RDATA_IDLE: assert property (!rd_in |=> r.rdata == 8'h00)
        else $error("read data outside read cycle");
    AST_MON_FLAG: assert property ($rose(mon_slow[0]) |=> r.mon_flag[0] && r.irq_stat[1])
        else $error("monitor flag not reported");
    AST_EXT_SEL: assert property ($past(r.ext_sel) |-> g_mon[2].u_mon.r.sync1 == $past(ext_clk_in, 3))
        else $error("oscillator monitor not on external clock");
endmodule

// ### vcc_pkg.sv
package vcc_pkg;
    // Register map
    localparam int VCC_ADDR_W = 10;
    localparam logic [9:0] VCC_ADR_CAL_CTRL = 10'h018;
    localparam logic [9:0] VCC_ADR_MON_CTRL = 10'h01A;
    localparam logic [9:0] VCC_ADR_STATUS = 10'h01F;
    localparam logic [9:0] VCC_ADR_OSC_DIV = 10'h1E0;
    localparam logic [9:0] VCC_ADR_UPDATE = 10'h232;
    localparam logic [9:0] VCC_ADR_IRQ_STAT = 10'h240;
    localparam logic [9:0] VCC_ADR_IRQ_MASK = 10'h241;
    localparam logic [9:0] VCC_ADR_AUX_CTRL = 10'h242;

    // Field positions
    localparam int VCC_CAL_START_BIT = 0;
    localparam int VCC_CAL_DIV_LSB = 1;
    localparam int VCC_MON_THR_BIT = 6;
    localparam int VCC_DONE_BIT = 6;
    localparam int VCC_BUSY_BIT = 5;
    localparam int VCC_UPDATE_BIT = 0;
    localparam int VCC_EXT_SEL_BIT = 0;

    // Values after reset
    localparam logic [1:0] VCC_CAL_DIV_RST = 2'h0;
    localparam logic [2:0] VCC_OSC_DIV_RST = 3'h0;
    localparam logic [3:0] VCC_IRQ_MASK_RST = 4'h0;

    // Counts
    localparam int VCC_CAL_CYCLES = 4400;
    localparam int VCC_CNT_W = 16;
    localparam logic [15:0] VCC_MON_NORMAL_LIMIT = 16'h0032;
    localparam logic [15:0] VCC_MON_EXT_LIMIT = 16'h01F4;

    // Calibration sequence states
    typedef enum logic [2:0] {
        VCC_IDLE = 3'b000,
        VCC_SYNC = 3'b001,
        VCC_CAL = 3'b010,
        VCC_RELEASE = 3'b011,
        VCC_CLOSE = 3'b100
    } vcc_state_t;
endpackage

// ### vcc_freq_monitor.sv
module vcc_freq_monitor #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Watched clock and threshold
    input wire logic watch_pin_in,
    input wire logic [CNT_W-1:0] limit_in,
    // Below-threshold flag
    output logic slow_out
);
    import vcc_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [CNT_W-1:0] cnt;
        logic slow;
    } vcc_mon_regs_t;

    vcc_mon_regs_t r;
    vcc_mon_regs_t next_r;

    // Measure sys cycles between rising edges of the watched clock
    always_comb begin
        next_r = r;
        next_r.sync1 = watch_pin_in;
        next_r.sync2 = r.sync1;
        next_r.prev = r.sync2;
        if (r.sync2 && !r.prev) begin
            next_r.cnt = '0;
            next_r.slow = 1'b0;
        end else begin
            if (r.cnt != '1) begin
                next_r.cnt = r.cnt + 1'b1;
            end
            if (r.cnt >= limit_in) begin
                next_r.slow = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign slow_out = r.slow;
endmodule

// ### test_vco_calibration_controller.sv
module test_vco_calibration_controller;
    timeunit 1ns;
    timeprecision 1ps;
    import vcc_pkg::*;
    logic clk_sys_in, rst_in, wr_in, rd_in, phase_compare_rate_pulse_in, autoload_cal_in;
    logic reference_input_1_in, reference_input_2_in, osc_clk_in, ext_clk_in;
    logic [VCC_ADDR_W-1:0] addr_in;
    logic [7:0] wr_data_in, rd_data_out, seed, exp_q[$];
    logic output_sync_out, loop_close_out, irq_out, pmode, rd_d;
    logic [2:0] osc_div_out, mon_slow_out;
    logic [3:0] tog;
    int miscompares = 0, samples_checked = 0, cyc = 0, pcnt = 0;
    vcc_cal_ctrl #(.CAL_CYCLES(4)) i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
        .phase_compare_rate_pulse_in(phase_compare_rate_pulse_in), .autoload_cal_in(autoload_cal_in),
        .reference_input_1_in(reference_input_1_in), .reference_input_2_in(reference_input_2_in),
        .osc_clk_in(osc_clk_in), .ext_clk_in(ext_clk_in), .output_sync_out(output_sync_out),
        .loop_close_out(loop_close_out), .osc_div_out(osc_div_out), .mon_slow_out(mon_slow_out),
        .irq_out(irq_out));
    // Pseudo-random source for phase pulses
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    // Clock pins toggle every four cycles where enabled; phase pulses steady or random
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        seed <= lfsr(seed);
        phase_compare_rate_pulse_in <= pmode ? seed[0] : 1'b1;
        if (cyc[1:0] == 2'h0) begin
            {ext_clk_in, osc_clk_in, reference_input_2_in, reference_input_1_in} <=
                {ext_clk_in, osc_clk_in, reference_input_2_in, reference_input_1_in} ^ tog;
        end
        if (cyc == 30000) begin
            miscompares = miscompares + 1;
            stop_test();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        samples_checked = samples_checked + 1;
        if (seen !== expv) begin
            miscompares = miscompares + 1;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expv);
        end
    endtask
    // Read data stand one cycle after the strobe; oldest note is compared
    always @(negedge clk_sys_in) begin
        if (rd_d === 1'b1) check(rd_data_out, exp_q.pop_front());
        rd_d <= rd_in;
        if (output_sync_out === 1'b1 && phase_compare_rate_pulse_in === 1'b1) pcnt = pcnt + 1;
    end
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
    endtask
    // Waits up to n cycles for the sync output to reach v; returns whether it did
    task automatic wait_sync(input logic v, input int n, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < n && !ok; i++) begin
            @(negedge clk_sys_in);
            ok = (output_sync_out === v);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        logic ok;
        rst_in = 1'b1;
        {wr_in, rd_in, autoload_cal_in, pmode, rd_d} = '0;
        {reference_input_1_in, reference_input_2_in, osc_clk_in, ext_clk_in} = '0;
        addr_in = '0;
        wr_data_in = '0;
        seed = 8'h1A;
        tog = 4'h7;
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        // Reset values, unmapped and self-clearing places
        rd(VCC_ADR_STATUS, 8'h00);
        rd(10'h3FF, 8'h00);
        rd(VCC_ADR_UPDATE, 8'h00);
        rd(VCC_ADR_IRQ_MASK, 8'h00);
        @(negedge clk_sys_in);
        check({output_sync_out, loop_close_out, irq_out}, 8'h00);
        $display("test reset done");
        // First calibration: start bit then update, divider /2
        pcnt = 0;
        wr(VCC_ADR_CAL_CTRL, 8'h01);
        wr(VCC_ADR_UPDATE, 8'h01);
        wait_sync(1'b1, 3, ok);
        check(ok, 1'b1);
        check(loop_close_out, 1'b0);
        wait_sync(1'b0, 40, ok);
        check(ok && pcnt >= 8 && pcnt <= 10, 1'b1);
        @(negedge clk_sys_in);
        check(loop_close_out, 1'b1);
        rd(VCC_ADR_STATUS, 8'h40);
        rd(VCC_ADR_IRQ_STAT, 8'h01);
        @(negedge clk_sys_in);
        check(irq_out, 1'b0);
        wr(VCC_ADR_IRQ_MASK, 8'h01);
        @(negedge clk_sys_in);
        check(irq_out, 1'b1);
        wr(VCC_ADR_IRQ_STAT, 8'h01);
        @(negedge clk_sys_in);
        check(irq_out, 1'b0);
        $display("test first calibration done");
        // Update with start still 1 and a divider change starts nothing
        wr(VCC_ADR_OSC_DIV, 8'h03);
        wr(VCC_ADR_UPDATE, 8'h01);
        wait_sync(1'b1, 20, ok);
        check(ok, 1'b0);
        check(osc_div_out, 3'h3);
        $display("test no recalibration done");
        // Later calibration: 0, update, 1, update; divider /16 with random pulses
        pmode = 1'b1;
        pcnt = 0;
        wr(VCC_ADR_CAL_CTRL, 8'h00);
        wr(VCC_ADR_UPDATE, 8'h01);
        wr(VCC_ADR_CAL_CTRL, 8'h07);
        wr(VCC_ADR_UPDATE, 8'h01);
        wait_sync(1'b1, 3, ok);
        check(ok, 1'b1);
        rd(VCC_ADR_STATUS, 8'h20);
        wait_sync(1'b0, 2000, ok);
        check(ok && pcnt >= 64 && pcnt <= 66, 1'b1);
        rd(VCC_ADR_STATUS, 8'h40);
        $display("test recalibration done");
        // Loader start pulse
        @(posedge clk_sys_in);
        autoload_cal_in <= 1'b1;
        @(posedge clk_sys_in);
        autoload_cal_in <= 1'b0;
        wait_sync(1'b1, 3, ok);
        check(ok, 1'b1);
        wait_sync(1'b0, 2000, ok);
        check(ok, 1'b1);
        $display("test autoload done");
        // Monitors: stopped second reference, extended threshold, external clock select
        tog = 4'h5;
        repeat (80) @(negedge clk_sys_in);
        check(mon_slow_out, 3'h2);
        rd(VCC_ADR_STATUS, 8'h42);
        wr(VCC_ADR_MON_CTRL, 8'h40);
        wr(VCC_ADR_UPDATE, 8'h01);
        tog = 4'h6;
        repeat (80) @(negedge clk_sys_in);
        check(mon_slow_out, 3'h0);
        repeat (500) @(negedge clk_sys_in);
        check(mon_slow_out, 3'h1);
        wr(VCC_ADR_AUX_CTRL, 8'h01);
        tog = 4'h9;
        repeat (80) @(negedge clk_sys_in);
        check(mon_slow_out[2], 1'b0);
        tog = 4'h5;
        repeat (80) @(negedge clk_sys_in);
        check(mon_slow_out[2], 1'b1);
        rd(VCC_ADR_IRQ_STAT, 8'h0F);
        repeat (3) @(negedge clk_sys_in);
        $display("test monitors done");
        stop_test();
    end
endmodule
